/* logic/tcr_test_config.v */
`timescale 1ns/100ps
`default_nettype none
`include "tcr_consts.vh"
module tcr_test_config (
    input wire clock,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire valid_packet,
    input wire por_trip,
    input wire shutdown_entered,
    output reg timeout_counter_reset,
    output reg shutdown_request,
    output reg [3:0] regulator_test_select,
    output reg [15:0] balance_outputs,
    output reg [15:0] squeeze_outputs,
    output reg negative_pump_monitor_enable,
    output reg module_voltage_monitor_enable
);
    reg [15:0] cfg_q;
    reg [15:0] bal_q;
    reg aw_q;
    reg w_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire armed;
    wire do_write;
    wire [7:0] wa;
    wire [31:0] wd;
    wire [3:0] ws;
    wire arm;

    function [15:0] merge;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge = old;
            if (strb[0]) begin
                merge[7:0] = data[7:0];
            end
            if (strb[1]) begin
                merge[15:8] = data[15:8];
            end
        end
    endfunction

    assign wa = aw_q ? awaddr_q : s_axi_awaddr;
    assign wd = w_q ? wdata_q : s_axi_wdata;
    assign ws = w_q ? wstrb_q : s_axi_wstrb;
    assign do_write = (aw_q | s_axi_awvalid) & (w_q | s_axi_wvalid)
        & ~s_axi_bvalid;
    assign arm = do_write & (wa == `TCR_ADDR_TEST_CONFIG) & ws[0]
        & wd[`TCR_BIT_POR_SHDN];

    tcr_shutdown_latch u_latch (
        .clock(clock),
        .rst_n(rst_n),
        .arm(arm),
        .shutdown_entered(shutdown_entered),
        .armed_q(armed)
    );

    // Write channel: address and data taken in either order
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            cfg_q <= `TCR_RESET_VALUE;
            bal_q <= 16'h0000;
        end else begin
            s_axi_awready <= ~aw_q & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= ~w_q & ~s_axi_wready & ~s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (aw_q & w_q & ~s_axi_bvalid) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `TCR_RESP_OKAY;
                if (awaddr_q == `TCR_ADDR_TEST_CONFIG) begin
                    cfg_q <= merge(cfg_q, wdata_q, wstrb_q)
                        & `TCR_WRITE_MASK;
                end else if (awaddr_q == `TCR_ADDR_BAL_ENABLE) begin
                    bal_q <= merge(bal_q, wdata_q, wstrb_q);
                end else begin
                    s_axi_bresp <= `TCR_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `TCR_RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                if (s_axi_araddr == `TCR_ADDR_TEST_CONFIG) begin
                    // Bit 6 always reads zero
                    s_axi_rdata <= {16'h0000,
                        cfg_q & `TCR_READ_MASK};
                end else if (s_axi_araddr == `TCR_ADDR_BAL_ENABLE) begin
                    s_axi_rdata <= {16'h0000, bal_q};
                end else if (s_axi_araddr == `TCR_ADDR_STATUS) begin
                    s_axi_rdata <= {31'h0, armed};
                end else begin
                    s_axi_rresp <= `TCR_RESP_SLVERR;
                end
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control outputs, all registered
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timeout_counter_reset <= 1'b0;
            shutdown_request <= 1'b0;
            regulator_test_select <= 4'h0;
            balance_outputs <= 16'h0000;
            squeeze_outputs <= 16'h0000;
            negative_pump_monitor_enable <= 1'b0;
            module_voltage_monitor_enable <= 1'b0;
        end else begin
            timeout_counter_reset <= valid_packet
                & ~cfg_q[`TCR_BIT_CNT_INHIBIT];
            shutdown_request <= por_trip & armed
                & ~shutdown_entered;
            regulator_test_select <= cfg_q[11:8];
            if (cfg_q[`TCR_BIT_SQUEEZE]) begin
                squeeze_outputs <= bal_q;
                balance_outputs <= 16'h0000;
            end else begin
                squeeze_outputs <= 16'h0000;
                balance_outputs <= bal_q;
            end
            negative_pump_monitor_enable <=
                cfg_q[`TCR_BIT_PUMP_MON];
            module_voltage_monitor_enable <=
                cfg_q[`TCR_BIT_MODULE_MON];
        end
    end
endmodule
`default_nettype wire

/* logic/tcr_consts.vh */
// Functional notes
// - Bits 15:12 read zero; reserved bits 15:12, 5, 3, 1 written zero.
// - Bit 7 set blocks timeout counter reset on valid packets.
// - Bit 6 set makes supply power-on-reset trip enter shutdown.
// - Bit 6 latches; always reads zero; latch clears at shutdown.
// - Bit 4 routes balance enables to squeeze resistors, not balancing.
// - Bit 2 enables negative pump monitor; zero measures monitor ground.
// - Bit 0 enables module voltage monitor; zero measures its ground.
// - Balance enable bit n drives squeeze resistor of channel n+1.
`ifndef TCR_CONSTS_VH
`define TCR_CONSTS_VH
`define TCR_IDX_TEST_CONFIG 8'h1E
`define TCR_ADDR_TEST_CONFIG 8'h78
`define TCR_ADDR_BAL_ENABLE 8'h50
`define TCR_ADDR_STATUS 8'h80
`define TCR_RESET_VALUE 16'h0000
`define TCR_WRITE_MASK 16'h0FD5
`define TCR_READ_MASK 16'h0F95
`define TCR_BIT_CNT_INHIBIT 7
`define TCR_BIT_POR_SHDN 6
`define TCR_BIT_SQUEEZE 4
`define TCR_BIT_PUMP_MON 2
`define TCR_BIT_MODULE_MON 0
`define TCR_RESP_OKAY 2'b00
`define TCR_RESP_SLVERR 2'b10
`endif

/* logic/tcr_shutdown_latch.v */
`timescale 1ns/100ps
`default_nettype none
`include "tcr_consts.vh"
module tcr_shutdown_latch (
    input wire clock,
    input wire rst_n,
    input wire arm,
    input wire shutdown_entered,
    output reg armed_q
);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (arm) begin
            // A fresh arming in the shutdown cycle is kept
            armed_q <= 1'b1;
        end else if (shutdown_entered) begin
            armed_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* test/tcr_test_config_props.sv */
`timescale 1ns/100ps
`default_nettype none
module tcr_test_config_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic valid_packet,
    input wire logic timeout_counter_reset,
    input wire logic por_trip,
    input wire logic shutdown_entered,
    input wire logic shutdown_request,
    input wire logic [15:0] balance_outputs,
    input wire logic [15:0] squeeze_outputs
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_tcr; timeout_counter_reset |-> $past(valid_packet); endproperty
    property p_sq; balance_outputs == '0 || squeeze_outputs == '0; endproperty
    property p_shd;
        shutdown_request |-> $past(por_trip) && !$past(shutdown_entered);
    endproperty
    property p_clr; shutdown_entered |=> !shutdown_request; endproperty
    property p_b;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rl; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    property p_up; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_tcr: assert property (p_tcr) else $error("stray counter reset");
    a_sq: assert property (p_sq) else $error("both paths on");
    a_shd: assert property (p_shd) else $error("stray shutdown");
    a_clr: assert property (p_clr) else $error("shutdown held");
    a_b: assert property (p_b) else $error("write response moved");
    a_r: assert property (p_r) else $error("read data moved");
    a_rl: assert property (p_rl) else $error("read answer late");
    a_up: assert property (p_up) else $error("upper lanes set");
    c_shd: cover property (shutdown_request);
    c_sq: cover property (squeeze_outputs != '0);
    c_tcr: cover property (timeout_counter_reset);
endmodule
`default_nettype wire

/* test/test_test_configuration_register.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tcr_consts.vh"
module test_test_configuration_register;
    localparam logic [7:0] ad_cf = `TCR_ADDR_TEST_CONFIG;
    localparam logic [7:0] ad_st = `TCR_ADDR_STATUS;
    localparam logic [1:0] ok = 2'h0, er = 2'h2;
    logic clock = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic valid_packet = 0, por_trip = 0, shutdown_entered = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, timeout_counter_reset, shutdown_request;
    wire negative_pump_monitor_enable, module_voltage_monitor_enable;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] regulator_test_select;
    wire [15:0] balance_outputs, squeeze_outputs;
    int miscompares = 0, checks = 0;
    always #2.5 clock = ~clock;
    tcr_test_config dut_u (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .valid_packet,
        .por_trip, .shutdown_entered, .timeout_counter_reset,
        .shutdown_request, .regulator_test_select, .balance_outputs,
        .squeeze_outputs, .negative_pump_monitor_enable,
        .module_voltage_monitor_enable);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, r);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
    endtask
    task settle;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task pkt(input logic e);
        @(posedge clock) valid_packet <= 1'b1;
        @(posedge clock) valid_packet <= 1'b0;
        #1 chk(timeout_counter_reset, e);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rd(ad_cf, 32'h0, ok);
        rd(ad_st, 32'h0, ok);
        wr(ad_cf, 16'h0FD5, ok);
        rd(ad_cf, 32'h0F95, ok);
        settle;
        chk(regulator_test_select, 4'hF);
        chk(negative_pump_monitor_enable, 1'h1);
        chk(module_voltage_monitor_enable, 1'h1);
        wr(ad_cf, 16'h0000, ok);
        rd(ad_st, 32'h1, ok);
        settle;
        chk(negative_pump_monitor_enable, 1'h0);
        chk(module_voltage_monitor_enable, 1'h0);
        @(posedge clock) por_trip <= 1'b1;
        settle;
        chk(shutdown_request, 1'h1);
        @(posedge clock) shutdown_entered <= 1'b1;
        @(posedge clock) shutdown_entered <= 1'b0;
        settle;
        chk(shutdown_request, 1'h0);
        rd(ad_st, 32'h0, ok);
        @(posedge clock) por_trip <= 1'b0;
        wr(ad_cf, 16'h0080, ok);
        pkt(1'b0);
        wr(ad_cf, 16'h0000, ok);
        pkt(1'b1);
        wr(`TCR_ADDR_BAL_ENABLE, 16'h8001, ok);
        settle;
        chk(balance_outputs, 16'h8001);
        wr(ad_cf, 16'h0010, ok);
        settle;
        chk(squeeze_outputs, 16'h8001);
        chk(balance_outputs, 16'h0000);
        s_axi_wstrb <= 4'h2;
        wr(ad_cf, 16'h0305, ok);
        s_axi_wstrb <= 4'hF;
        rd(ad_cf, 32'h0310, ok);
        settle;
        chk(regulator_test_select, 4'h3);
        chk(squeeze_outputs, 16'h8001);
        chk(negative_pump_monitor_enable, 1'h0);
        wr(8'h04, 16'hFFFF, er);
        rd(8'h04, 32'h0, er);
        close_out;
    end
    initial begin
        #20000;
        miscompares++;
        close_out;
    end
endmodule
bind tcr_test_config tcr_test_config_props chk_u (.clock, .rst_n,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .valid_packet, .timeout_counter_reset, .por_trip, .shutdown_entered,
    .shutdown_request, .balance_outputs, .squeeze_outputs);
`default_nettype wire
